// File: pkg/gis_defs.vh
// Purpose: Offsets, field positions, reset values and command codes of the GPIB status block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Included by the design file only
`ifndef GIS_DEFS_VH
`define GIS_DEFS_VH

// Register byte offsets
`define GIS_OFF_STATUS0   8'h00
`define GIS_OFF_MASK0     8'h04
`define GIS_OFF_STATUS1   8'h08
`define GIS_OFF_MASK1     8'h0C
`define GIS_OFF_CONTROL   8'h10
`define GIS_OFF_ENDSTR    8'h14

// First status register fields
`define GIS_S0_END        3
`define GIS_S0_SERIAL_POLL_DONE_FLAG       2
`define GIS_S0_RLC        1
`define GIS_S0_MAC        0

// Second status register fields
`define GIS_S1_GET        7
`define GIS_S1_ERR        6
`define GIS_S1_UNC        5
`define GIS_S1_APT        4
`define GIS_S1_DEVICE_CLEAR_FLAG       3
`define GIS_S1_MA         2
`define GIS_S1_SRQ        1
`define GIS_S1_IFC        0

// Control register fields
`define GIS_C_SWRST       0
`define GIS_C_RELEASE     1
`define GIS_C_END_ON_STRING_ENABLE        2
`define GIS_C_NEWLINE_END_ENABLE        3
`define GIS_C_EDPA        4

// Reset values
`define GIS_RST_MASK      8'h00
`define GIS_RST_STATUS    8'h00
`define GIS_RST_CONTROL   8'h00
`define GIS_RST_ENDSTR    8'h00

// Bus byte and command codes
`define GIS_NEWLINE       8'h0A
`define GIS_CMD_GTL       8'h01
`define GIS_CMD_SDC       8'h04
`define GIS_CMD_PPC       8'h05
`define GIS_CMD_GET       8'h08
`define GIS_CMD_TCT       8'h09
`define GIS_CMD_LLO       8'h11
`define GIS_CMD_DCL       8'h14
`define GIS_CMD_PPU       8'h15
`define GIS_CMD_SPE       8'h18
`define GIS_CMD_SPD       8'h19
`define GIS_CMD_UNL       8'h3F

`endif

// File: design/gis_irq_status.v
// Purpose: Interrupt status, masks, trigger pin and accept holdoff of a GPIB interface
// Assumes: Protocol state bits arrive as synchronous levels from the interface state machines
// Notes:   Registers on classic Wishbone; status registers clear on read
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "gis_defs.vh"

// How it works
// - Listener byte equal to end string sets end flag when string end enabled.
// - Listener byte equal to newline sets end flag when newline end enabled.
// - Listener byte accepted with EOI asserted sets end flag.
// - Serial-poll flag sets when transmit, active and affirm combination falls.
// - Remote/local flag sets whenever the remote state bit changes.
// - Address-change flag sets on new address, other talk, or unlisten.
// - With secondary addressing, address-change flag sets only on unaddressing.
// - Dual primary option: readdressing at other primary address sets nothing.
// - Second status flags set and clear regardless of second mask.
// - Event during a second status read is held and set after the read.
// - Hardware reset clears the whole second mask register.
// - Flag setting with its enable one can raise the interrupt request.
// - Enabled trigger, unrecognized, pass, clear or my-address event holds off accept.
// - Trigger flag sets on GET accepted while listener addressed.
// - Trigger enabled: trigger pin high from event until holdoff release.
// - Trigger disabled: trigger pin gives one single high pulse.
// - Error flag sets on entering source delay with no acceptors present.
// - Accepted universal command not decoded here sets unrecognized flag.
// - Addressed listener: accepted undecoded addressed command sets unrecognized flag.
module gis_irq_status (
  input  wire        mclk_in,       // 100 MHz clock
  input  wire        arst_n_in,     // Async reset, active low
  input  wire        wb_cyc_in,     // Wishbone cycle
  input  wire        wb_stb_in,     // Wishbone strobe
  input  wire        wb_we_in,      // Wishbone write enable
  input  wire [7:0]  wb_adr_in,     // Wishbone byte address
  input  wire [3:0]  wb_sel_in,     // Wishbone byte selects
  input  wire [31:0] wb_dat_in,     // Wishbone write data
  output reg  [31:0] wb_dat_out,    // Wishbone read data
  output reg         wb_ack_out,    // Wishbone acknowledge
  input  wire        acds_in,       // Byte accepted strobe
  input  wire        atn_in,        // Byte is a command
  input  wire [7:0]  bus_data_in,   // Byte on the bus
  input  wire        eoi_in,        // EOI asserted with byte
  input  wire        lacs_in,       // Listener active
  input  wire        lads_in,       // Listener addressed
  input  wire        tads_in,       // Talker addressed
  input  wire        mta_in,        // Byte is a talk address of ours
  input  wire        mla_in,        // Byte is a listen address of ours
  input  wire        ota_in,        // Byte is some other talk address
  input  wire        pp1_in,        // Parallel poll config mode
  input  wire        strs_in,       // Status transmit state
  input  wire        serial_poll_done_flag_in,       // Serial poll active state
  input  wire        aprs_in,       // Affirmative poll response
  input  wire        remote_in,     // Remote state bit
  input  wire        sdys_in,       // Source delay state
  input  wire        ndac_in,       // NDAC asserted on bus
  input  wire        nrfd_in,       // NRFD asserted on bus
  input  wire        apt_event_in,  // Pass-through event
  input  wire        ma_event_in,   // My address event
  input  wire        srq_event_in,  // Service request event
  input  wire        ifc_event_in,  // Interface clear event
  output reg         irq_out,       // Interrupt request
  output reg         dac_hold_out,  // Data-accepted holdoff
  output reg         trigger_out    // Trigger output pin
);

  reg  [7:0] stat0_q;
  reg  [7:0] stat1_q;
  reg  [7:0] pend0_q;
  reg  [7:0] pend1_q;
  reg  [7:0] mask0_q;
  reg  [7:0] mask1_q;
  reg  [7:0] endstr_q;
  reg        end_on_string_enable_q;
  reg        newline_end_enable_q;
  reg        edpa_q;
  reg        poll_q;
  reg        remote_q;
  reg        sdys_q;
  reg  [7:0] ev0;
  reg  [7:0] ev1;
  reg  [31:0] rdata;

  wire       req     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire       wr_now  = req & wb_we_in & wb_sel_in[0];
  wire       rd_s0   = req & ~wb_we_in & (wb_adr_in == `GIS_OFF_STATUS0);
  wire       rd_s1   = req & ~wb_we_in & (wb_adr_in == `GIS_OFF_STATUS1);
  wire       wr_ctl  = wr_now & (wb_adr_in == `GIS_OFF_CONTROL);
  wire       swrst   = wr_ctl & wb_dat_in[`GIS_C_SWRST];
  // Named apart from the force/release keyword, which a strict front end refuses
  wire       rel_cmd = wr_ctl & wb_dat_in[`GIS_C_RELEASE];
  wire       poll    = strs_in & serial_poll_done_flag_in & aprs_in;
  wire       data_ok = acds_in & ~atn_in & lacs_in;
  wire       cmd_ok  = acds_in & atn_in;
  wire [7:0] cb      = bus_data_in;
  wire       ucg     = (cb[7:4] == 4'h1);
  wire       acg     = (cb[7:4] == 4'h0);
  wire       ucg_known = (cb == `GIS_CMD_LLO) | (cb == `GIS_CMD_SPE) |
                         (cb == `GIS_CMD_SPD) | (cb == `GIS_CMD_DCL) |
                         ((cb == `GIS_CMD_PPU) & pp1_in);
  wire       acg_known = (cb == `GIS_CMD_GET) | (cb == `GIS_CMD_GTL) |
                         (cb == `GIS_CMD_SDC) | (cb == `GIS_CMD_TCT) |
                         ((cb == `GIS_CMD_PPC) & pp1_in);
  wire       sec_addr = mask1_q[`GIS_S1_APT];
  // Held flags of the command group that throttle the handshake
  wire [7:0] hold_bits = 8'h80 | 8'h20 | 8'h10 | 8'h08 | 8'h04;

  // Raw events, before the read postponement
  always @* begin
    ev0 = 8'h00;
    ev1 = 8'h00;
    ev0[`GIS_S0_END] = data_ok & (
                         (end_on_string_enable_q & (cb == endstr_q)) |
                         (newline_end_enable_q & (cb == `GIS_NEWLINE)) |
                         eoi_in);
    ev0[`GIS_S0_SERIAL_POLL_DONE_FLAG] = poll_q & ~poll;
    ev0[`GIS_S0_RLC]  = remote_q ^ remote_in;
    // Secondary addressing hides the addressing edges
    ev0[`GIS_S0_MAC]  = cmd_ok & (
                          (mta_in & ~tads_in & ~sec_addr) |
                          (ota_in & ~mta_in & tads_in) |
                          (mla_in & ~lads_in & ~sec_addr) |
                          ((cb == `GIS_CMD_UNL) & lads_in));
    ev1[`GIS_S1_GET]  = cmd_ok & (cb == `GIS_CMD_GET) & lads_in;
    ev1[`GIS_S1_ERR]  = sdys_in & ~sdys_q & ~ndac_in & ~nrfd_in;
    ev1[`GIS_S1_UNC]  = cmd_ok & ((ucg & ~ucg_known) |
                                  (acg & ~acg_known & lads_in));
    ev1[`GIS_S1_APT]  = apt_event_in;
    ev1[`GIS_S1_DEVICE_CLEAR_FLAG] = cmd_ok & ((cb == `GIS_CMD_DCL) |
                                  ((cb == `GIS_CMD_SDC) & lads_in));
    ev1[`GIS_S1_MA]   = ma_event_in;
    ev1[`GIS_S1_SRQ]  = srq_event_in;
    ev1[`GIS_S1_IFC]  = ifc_event_in;
  end

  // Read mux; masks are write only and read back zero
  always @* begin
    rdata = 32'h0000_0000;
    case (wb_adr_in)
      `GIS_OFF_STATUS0: rdata = {24'h00_0000, stat0_q};
      `GIS_OFF_STATUS1: rdata = {24'h00_0000, stat1_q};
      `GIS_OFF_CONTROL: rdata = {27'h000_0000, edpa_q, newline_end_enable_q, end_on_string_enable_q, 2'b00};
      `GIS_OFF_ENDSTR:  rdata = {24'h00_0000, endstr_q};
      default:          rdata = 32'h0000_0000;
    endcase
  end

  // Bus slave: ack one cycle after the request, unmapped reads zero
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      if (req && !wb_we_in) begin
        wb_dat_out <= rdata;
      end
    end
  end

  // Writable configuration; hardware reset zeroes both masks
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask0_q  <= `GIS_RST_MASK;
      mask1_q  <= `GIS_RST_MASK;
      endstr_q <= `GIS_RST_ENDSTR;
      end_on_string_enable_q   <= 1'b0;
      newline_end_enable_q   <= 1'b0;
      edpa_q   <= 1'b0;
    end else if (wr_now) begin
      case (wb_adr_in)
        `GIS_OFF_MASK0:   mask0_q  <= wb_dat_in[7:0];
        `GIS_OFF_MASK1:   mask1_q  <= wb_dat_in[7:0];
        `GIS_OFF_ENDSTR:  endstr_q <= wb_dat_in[7:0];
        `GIS_OFF_CONTROL: begin
          end_on_string_enable_q <= wb_dat_in[`GIS_C_END_ON_STRING_ENABLE];
          newline_end_enable_q <= wb_dat_in[`GIS_C_NEWLINE_END_ENABLE];
          edpa_q <= wb_dat_in[`GIS_C_EDPA];
        end
        default: begin
        end
      endcase
    end
  end

  // Edge history for the level-change events
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      poll_q   <= 1'b0;
      remote_q <= 1'b0;
      sdys_q   <= 1'b0;
    end else begin
      poll_q   <= poll;
      remote_q <= remote_in;
      sdys_q   <= sdys_in;
    end
  end

  // Status flags: a read clears and parks concurrent events one cycle,
  // so an event in the read cycle lands after the clear and is not lost
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat0_q <= `GIS_RST_STATUS;
      stat1_q <= `GIS_RST_STATUS;
      pend0_q <= 8'h00;
      pend1_q <= 8'h00;
    end else begin
      if (swrst || rd_s0) begin
        stat0_q <= pend0_q;
        pend0_q <= ev0;
      end else begin
        stat0_q <= stat0_q | pend0_q | ev0;
        pend0_q <= 8'h00;
      end
      // Independent of the second mask
      if (swrst || rd_s1) begin
        stat1_q <= pend1_q;
        pend1_q <= ev1;
      end else begin
        stat1_q <= stat1_q | pend1_q | ev1;
        pend1_q <= 8'h00;
      end
    end
  end

  // Interrupt, holdoff and trigger pin
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out      <= 1'b0;
      dac_hold_out <= 1'b0;
      trigger_out  <= 1'b0;
    end else begin
      irq_out <= |((stat0_q & mask0_q) | (stat1_q & mask1_q));
      if (|(ev1 & mask1_q & hold_bits)) begin
        dac_hold_out <= 1'b1;
      end else if (rel_cmd) begin
        dac_hold_out <= 1'b0;
      end
      if (ev1[`GIS_S1_GET]) begin
        trigger_out <= 1'b1;
      end else if (!mask1_q[`GIS_S1_GET] || rel_cmd) begin
        trigger_out <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/gis_irq_status_sva.sv
// Purpose: Port-level checks of the GPIB status block
// Assumes: One clock, async active-low reset
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module gis_irq_status_sva (
  input wire logic       mclk_in,      // Clock
  input wire logic       arst_n_in,    // Reset
  input wire logic       wb_cyc_in,    // Cycle
  input wire logic       wb_stb_in,    // Strobe
  input wire logic       wb_we_in,     // Write
  input wire logic [7:0] wb_adr_in,    // Address
  input wire logic [3:0] wb_sel_in,    // Selects
  input wire logic [31:0] wb_dat_in,   // Write data
  input wire logic       wb_ack_out,   // Ack
  input wire logic       acds_in,      // Accept strobe
  input wire logic       atn_in,       // Command byte
  input wire logic       lads_in,      // Listener addressed
  input wire logic [7:0] bus_data_in,  // Bus byte
  input wire logic       apt_event_in, // Pass event
  input wire logic       ma_event_in,  // Address event
  input wire logic       irq_out,      // Interrupt
  input wire logic       dac_hold_out, // Holdoff
  input wire logic       trigger_out   // Trigger pin
);
  // Request taken, release write and holdoff causes
  wire logic take = wb_cyc_in & wb_stb_in & !wb_ack_out;
  wire logic wsel = take & wb_we_in & wb_sel_in[0];
  wire logic rel  = wsel & (wb_adr_in == 8'h10) & wb_dat_in[1];
  wire logic ev   = acds_in | apt_event_in | ma_event_in;
  logic      mask_seen_q;

  // Masks reset to zero, so no request is possible before one is written
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) mask_seen_q <= 1'h0;
    else if (wsel & (wb_adr_in[3:0] == 4'h4 | wb_adr_in[3:0] == 4'hC)) mask_seen_q <= 1'h1;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  a_ack_answers: assert property (take |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_irq_quiet: assert property (!mask_seen_q |-> !irq_out)
    else $error("irq with all masks clear");
  a_trig_cause: assert property ($rose(trigger_out) |->
    $past(acds_in & atn_in & lads_in) && $past(bus_data_in) == 8'h08)
    else $error("trigger without listener trigger command");
  a_trig_pulse: assert property ($rose(trigger_out) && !dac_hold_out |=> !trigger_out)
    else $error("trigger pulse too long");
  a_trig_stays: assert property (trigger_out && $past(trigger_out) && !rel |=> trigger_out)
    else $error("trigger fell before release");
  a_hold_cause: assert property ($rose(dac_hold_out) |-> $past(ev))
    else $error("holdoff without event");
  a_hold_stays: assert property (dac_hold_out && !rel |=> dac_hold_out)
    else $error("holdoff dropped without release");
  a_hold_drop: assert property (dac_hold_out && rel && !ev |=> !dac_hold_out)
    else $error("holdoff kept after release");
endmodule
`default_nettype wire

// File: testbench/gis_gpib_src.sv
// Purpose: Bus-side byte source for the status block
// Assumes: One accepted byte per send request
// Notes:   Idle data toggles, never a stale byte
`timescale 1ns/100ps
`default_nettype none
module gis_gpib_src (
  input  wire logic       clk_in,   // Clock
  input  wire logic       rst_n_in, // Reset
  input  wire logic       send_in,  // Send a byte
  input  wire logic [7:0] byte_in,  // Byte to send
  output var  logic       acds_out, // Accept strobe
  output var  logic [7:0] data_out  // Bus data
);
  // One strobe per request; idle data inverts so it cannot match by luck
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acds_out <= 1'h0;
      data_out <= 8'h00;
    end else begin
      acds_out <= send_in;
      data_out <= send_in ? byte_in : ~data_out;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_gis_irq_status.sv
// Purpose: Self-checking bench of the GPIB status block
// Assumes: Bus answers within 20 cycles
// Notes:   Checker bound at the foot
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module tb_gis_irq_status;
  logic        mclk_in = 1'h0, arst_n_in = 1'h0, snd = 1'h0;
  logic        wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0;
  logic [7:0]  wb_adr_in = 8'h00, sb = 8'h00, bus_data_in;
  logic [3:0]  wb_sel_in = 4'h1;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  logic        wb_ack_out, irq_out, dac_hold_out, trigger_out, acds_in;
  logic        atn_in = 1'h0, eoi_in = 1'h0, lacs_in = 1'h0, lads_in = 1'h0, tads_in = 1'h0;
  logic        mta_in = 1'h0, mla_in = 1'h0, ota_in = 1'h0, pp1_in = 1'h0, strs_in = 1'h0;
  logic        serial_poll_done_flag_in = 1'h0, aprs_in = 1'h0, remote_in = 1'h0, sdys_in = 1'h0, ndac_in = 1'h0;
  logic        nrfd_in = 1'h0, apt_event_in = 1'h0, ma_event_in = 1'h0;
  logic        srq_event_in = 1'h0, ifc_event_in = 1'h0;
  int          err_total = 0, samples_checked = 0, trig_n = 0, t0;

  // 100 MHz clock and trigger high-time count
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) trig_n <= trig_n + int'(trigger_out === 1'h1);

  gis_irq_status u_dut (.mclk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .acds_in, .atn_in, .bus_data_in, .eoi_in,
    .lacs_in, .lads_in, .tads_in, .mta_in, .mla_in, .ota_in, .pp1_in, .strs_in, .serial_poll_done_flag_in,
    .aprs_in, .remote_in, .sdys_in, .ndac_in, .nrfd_in, .apt_event_in, .ma_event_in,
    .srq_event_in, .ifc_event_in, .irq_out, .dac_hold_out, .trigger_out);
  gis_gpib_src u_src (.clk_in(mclk_in), .rst_n_in(arst_n_in), .send_in(snd), .byte_in(sb),
    .acds_out(acds_in), .data_out(bus_data_in));

  // Verdict, reached from the end and from any timeout
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, w, a, d};
    n = 0;
    do begin @(posedge mclk_in); n++; end while (wb_ack_out !== 1'h1 && n < 20);
    q = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'h0;
    if (wb_ack_out !== 1'h1) begin err_total++; stop_test(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK(q, e)
  endtask
  // One byte accepted on the bus, then time for flags to land
  task automatic send(input logic [7:0] b, input logic a);
    @(posedge mclk_in);
    {snd, sb, atn_in} <= {1'h1, b, a};
    @(posedge mclk_in);
    snd <= 1'h0;
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic pulse(input logic [1:0] v);
    {apt_event_in, ma_event_in} <= v;
    @(posedge mclk_in);
    {apt_event_in, ma_event_in} <= 2'h0;
    repeat (3) @(posedge mclk_in);
  endtask

  initial begin
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'h1;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    // End of message by string, newline and EOI, then with all disabled
    wr(8'h14, 32'h5A);
    wr(8'h10, 32'h0C);
    lacs_in <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      eoi_in <= (i == 2);
      send(i == 0 ? 8'h5A : (i == 1 ? 8'h0A : 8'h33), 1'h0);
      rd(8'h00, 32'h08);
    end
    rd(8'h00, 32'h0);
    wr(8'h10, 32'h0);
    eoi_in <= 1'h0;
    send(8'h0A, 1'h0);
    rd(8'h00, 32'h0);
    $display("test end done");
    // Poll completion, remote change, address changes
    {strs_in, serial_poll_done_flag_in, aprs_in, lacs_in} <= 4'hE;
    repeat (2) @(posedge mclk_in);
    {serial_poll_done_flag_in, remote_in, mla_in} <= 3'h3;
    repeat (3) @(posedge mclk_in);
    rd(8'h00, 32'h06);
    send(8'h25, 1'h1);
    rd(8'h00, 32'h01);
    wr(8'h0C, 32'h10);
    send(8'h25, 1'h1);
    rd(8'h00, 32'h0);
    {mla_in, lads_in} <= 2'h1;
    send(8'h3F, 1'h1);
    rd(8'h00, 32'h01);
    // Talker readdressed at its other primary address, then by another talker
    {tads_in, mta_in, ota_in} <= 3'h7;
    send(8'h41, 1'h1);
    rd(8'h00, 32'h0);
    mta_in <= 1'h0;
    send(8'h42, 1'h1);
    rd(8'h00, 32'h01);
    {tads_in, ota_in} <= 2'h0;
    $display("test address done");
    // Second register with masks clear: trigger, unknown command, error
    wr(8'h0C, 32'h0);
    t0 = trig_n;
    send(8'h08, 1'h1);
    `CHK(trig_n - t0, 1)
    rd(8'h08, 32'h80);
    send(8'h02, 1'h1);
    rd(8'h08, 32'h20);
    lads_in <= 1'h0;
    send(8'h02, 1'h1);
    rd(8'h08, 32'h0);
    sdys_in <= 1'h1;
    repeat (3) @(posedge mclk_in);
    rd(8'h08, 32'h40);
    {sdys_in, ndac_in} <= 2'h1;
    @(posedge mclk_in);
    sdys_in <= 1'h1;
    repeat (3) @(posedge mclk_in);
    rd(8'h08, 32'h0);
    $display("test events done");
    // Enabled trigger holds the pin and the handshake until release
    wr(8'h0C, 32'h80);
    lads_in <= 1'h1;
    send(8'h08, 1'h1);
    repeat (4) @(posedge mclk_in);
    `CHK({trigger_out, dac_hold_out, irq_out}, 3'h7)
    wr(8'h10, 32'h02);
    `CHK({trigger_out, dac_hold_out}, 2'h0)
    rd(8'h08, 32'h80);
    @(posedge mclk_in);
    `CHK(irq_out, 1'h0)
    // Each other holdoff source: unknown command, pass, clear, my address
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, 32'h20 >> i);
      if (i[0]) pulse(i == 1 ? 2'h2 : 2'h1);
      else send(i == 0 ? 8'h13 : 8'h14, 1'h1);
      `CHK(dac_hold_out, 1'h1)
      wr(8'h10, 32'h02);
      `CHK(dac_hold_out, 1'h0)
      rd(8'h08, 32'h20 >> i);
    end
    $display("test holdoff done");
    // Soft reset clears both status registers
    {remote_in, srq_event_in, ifc_event_in} <= 3'h3;
    @(posedge mclk_in);
    {srq_event_in, ifc_event_in} <= 2'h0;
    repeat (2) @(posedge mclk_in);
    wr(8'h10, 32'h01);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    $display("test soft reset done");
    stop_test();
  end
endmodule
bind gis_irq_status gis_irq_status_sva u_sva (.mclk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .acds_in, .atn_in, .lads_in,
  .bus_data_in, .apt_event_in, .ma_event_in, .irq_out, .dac_hold_out, .trigger_out);
`default_nettype wire
